// ===== ldorc_pkg.sv
// Package for the regulator control register bank: offsets, fields, resets, timing.
// Assumes a 125 MHz APB clock and 32-bit APB data.
package ldorc_pkg;

  localparam int unsigned LDORC_CLK_MHZ = 125;

  // Register indices; byte address is four times the index
  localparam logic [7:0] LDORC_IDX_A = 8'h32;
  localparam logic [7:0] LDORC_IDX_B = 8'h33;
  localparam logic [7:0] LDORC_IDX_STATUS = 8'h34;
  localparam logic [11:0] LDORC_ADDR_A = {2'h0, LDORC_IDX_A, 2'h0};
  localparam logic [11:0] LDORC_ADDR_B = {2'h0, LDORC_IDX_B, 2'h0};
  localparam logic [11:0] LDORC_ADDR_STATUS = {2'h0, LDORC_IDX_STATUS, 2'h0};

  // Control register fields
  localparam int unsigned LDORC_A_CODE_W = 5;
  localparam int unsigned LDORC_B_CODE_W = 6;
  localparam int unsigned LDORC_EN_BIT = 6;
  localparam int unsigned LDORC_PRESET_BIT = 7;

  // Highest distinct codes; anything above selects the same top voltage
  localparam logic [5:0] LDORC_A_CODE_MAX = 6'h18;
  localparam logic [5:0] LDORC_B_CODE_MAX = 6'h30;

  // Reset values
  localparam logic [7:0] LDORC_A_RESET = 8'h0C;
  localparam logic [7:0] LDORC_B_RESET = 8'h18;

  // Status register fields
  localparam int unsigned LDORC_ST_B_CODE_LSB = 0;
  localparam int unsigned LDORC_ST_A_CODE_LSB = 8;
  localparam int unsigned LDORC_ST_A_EN_BIT = 16;
  localparam int unsigned LDORC_ST_B_EN_BIT = 17;
  localparam int unsigned LDORC_ST_RAMP_BIT = 18;
  localparam int unsigned LDORC_ST_PD_BIT = 19;

  // Time per ramp step and its cycle count
  localparam int unsigned LDORC_RAMP_STEP_NS = 80;
  localparam int unsigned LDORC_RAMP_STEP_CYC_RAW = (LDORC_RAMP_STEP_NS * LDORC_CLK_MHZ) / 1000;
  localparam int unsigned LDORC_RAMP_STEP_CYC = (LDORC_RAMP_STEP_CYC_RAW < 1) ? 1 : LDORC_RAMP_STEP_CYC_RAW;

  typedef enum logic [1:0]
  {
    LDORC_RAMP_IDLE = 2'h0,
    LDORC_RAMP_WAIT = 2'h1,
    LDORC_RAMP_STEP = 2'h3
  } ldorc_ramp_st_t;

endpackage

// ===== ldorc_ramp.sv
// Ramp engine: walks an output code one step at a time toward a latched target.
// Assumes start is a one-cycle pulse with target valid in the same cycle.
`timescale 1ns/1ps
module ldorc_ramp
#(
  parameter int unsigned CODE_W = 6,
  parameter int unsigned STEP_CYC = ldorc_pkg::LDORC_RAMP_STEP_CYC,
  parameter logic [CODE_W-1:0] INIT_CODE = '0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [CODE_W-1:0] target,
  output logic [CODE_W-1:0] code,
  output logic busy
);
  import ldorc_pkg::*;

  typedef struct packed
  {
    ldorc_ramp_st_t st;
    logic [CODE_W-1:0] goal;
    logic [CODE_W-1:0] cur;
    logic [15:0] cnt;
    logic busy;
  } ldorc_ramp_s_t;

  ldorc_ramp_s_t s_q;
  ldorc_ramp_s_t s_d;

  initial
  begin
    if (STEP_CYC < 1 || STEP_CYC > 65535 || CODE_W < 1)
    begin
      $error("ldorc_ramp: unsupported parameters");
    end
  end

  always_comb
  begin
    s_d = s_q;
    // A new start retargets even in mid-ramp
    if (start)
    begin
      s_d.goal = target;
      s_d.cnt = '0;
      s_d.st = (target == s_q.cur) ? LDORC_RAMP_IDLE : LDORC_RAMP_WAIT;
    end
    else
    begin
      case (s_q.st)
        LDORC_RAMP_IDLE:
        begin
          s_d.cnt = '0;
        end
        LDORC_RAMP_WAIT:
        begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.cnt == 16'(STEP_CYC - 1))
          begin
            s_d.st = LDORC_RAMP_STEP;
          end
        end
        LDORC_RAMP_STEP:
        begin
          s_d.cnt = '0;
          if (s_q.goal > s_q.cur)
          begin
            s_d.cur = s_q.cur + 1'b1;
          end
          else if (s_q.goal < s_q.cur)
          begin
            s_d.cur = s_q.cur - 1'b1;
          end
          s_d.st = (s_d.cur == s_q.goal) ? LDORC_RAMP_IDLE : LDORC_RAMP_WAIT;
        end
        default:
        begin
          s_d.st = LDORC_RAMP_IDLE;
        end
      endcase
    end
    // Registered so the port comes straight from a flop
    s_d.busy = (s_d.st != LDORC_RAMP_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.st <= LDORC_RAMP_IDLE;
      s_q.goal <= INIT_CODE;
      s_q.cur <= INIT_CODE;
      s_q.cnt <= '0;
      s_q.busy <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign code = s_q.cur;
  assign busy = s_q.busy;

endmodule

// ===== ldorc_regs.sv
// Control registers for two low-dropout regulators, reached over APB.
// Assumes a power-down sequencer driving power_down and a go pulse generator for regulator B.
//
// Behaviour
// - Regulator A takes a 5-bit code in bits 4:0, 0.600 V to 1.800 V in 50 mV steps, clamped above 11000, reset 01100.
// - With regulator A's bit 7 clear a new code applies at once, and bit 6 enables it, resetting to 0.
// - With regulator A's bit 7 set the code is a preset applied during power-down instead of disabling.
// - Regulator B takes a 6-bit code in bits 5:0, 0.600 V to 1.800 V in 25 mV steps, clamped above 110000, reset 011000.
// - With regulator B's bit 7 clear the output ramps to a new code only after go, and bit 6 enables it, resetting to 0.
// - With regulator B's bit 7 set the code is a preset that the output ramps to during power-down.
`timescale 1ns/1ps
module ldorc_regs
#(
  parameter int unsigned RAMP_STEP_CYC = ldorc_pkg::LDORC_RAMP_STEP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic power_down,
  input wire logic regulator_b_ramp_go,
  output logic [ldorc_pkg::LDORC_A_CODE_W-1:0] regulator_a_applied_code,
  output logic regulator_a_on,
  output logic [ldorc_pkg::LDORC_B_CODE_W-1:0] regulator_b_applied_code,
  output logic regulator_b_on,
  output logic regulator_b_ramping
);
  import ldorc_pkg::*;

  typedef struct packed
  {
    logic [LDORC_A_CODE_W-1:0] a_code;
    logic a_enable;
    logic a_preset_sel;
    logic [LDORC_B_CODE_W-1:0] b_code;
    logic b_enable;
    logic b_preset_sel;
    logic [LDORC_A_CODE_W-1:0] a_applied;
    logic a_on;
    logic b_on;
    logic pd_prev;
    logic ready;
    logic [31:0] rdata;
    logic slverr;
  } ldorc_regs_s_t;

  ldorc_regs_s_t s_q;
  ldorc_regs_s_t s_d;

  logic ramp_start;
  logic [LDORC_B_CODE_W-1:0] ramp_target;
  logic [LDORC_B_CODE_W-1:0] ramp_code;
  logic ramp_busy;
  logic access;
  logic commit;
  logic hit_a;
  logic hit_b;
  logic hit_st;

  initial
  begin
    if (RAMP_STEP_CYC < 1 || RAMP_STEP_CYC > 65535)
    begin
      $error("ldorc_regs: RAMP_STEP_CYC out of range");
    end
  end

  // Codes above the top step select the top voltage
  function automatic logic [5:0] clamp_code(input logic [5:0] code, input logic [5:0] top);
    clamp_code = (code > top) ? top : code;
  endfunction

  function automatic logic [11:0] word_addr(input logic [11:0] addr);
    word_addr = {addr[11:2], 2'h0};
  endfunction

  assign hit_a = (word_addr(paddr) == LDORC_ADDR_A);
  assign hit_b = (word_addr(paddr) == LDORC_ADDR_B);
  assign hit_st = (word_addr(paddr) == LDORC_ADDR_STATUS);

  // One wait state: ready rises on the second access cycle, where the write lands
  assign access = psel && penable;
  assign commit = access && s_q.ready;

  // ramp only on go while preset mode is off
  // power-down entry ramps to the preset
  always_comb
  begin
    ramp_start = 1'b0;
    ramp_target = clamp_code(s_q.b_code, LDORC_B_CODE_MAX);
    if (power_down && !s_q.pd_prev && s_q.b_preset_sel)
    begin
      ramp_start = 1'b1;
    end
    else if (regulator_b_ramp_go && !s_q.b_preset_sel && !power_down)
    begin
      ramp_start = 1'b1;
    end
  end

  ldorc_ramp
  #(
    .CODE_W(LDORC_B_CODE_W),
    .STEP_CYC(RAMP_STEP_CYC),
    .INIT_CODE(LDORC_B_RESET[LDORC_B_CODE_W-1:0])
  )
  u_ramp
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(ramp_start),
    .target(ramp_target),
    .code(ramp_code),
    .busy(ramp_busy)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.pd_prev = power_down;

    // Bus answer path
    s_d.ready = access && !s_q.ready;
    if (access && !s_q.ready)
    begin
      s_d.slverr = !(hit_a || hit_b || hit_st);
      s_d.rdata = 32'h0000_0000;
      if (!pwrite && hit_a)
      begin
        // Bit 5 is reserved and reads zero
        s_d.rdata[LDORC_A_CODE_W-1:0] = s_q.a_code;
        s_d.rdata[LDORC_EN_BIT] = s_q.a_enable;
        s_d.rdata[LDORC_PRESET_BIT] = s_q.a_preset_sel;
      end
      else if (!pwrite && hit_b)
      begin
        s_d.rdata[LDORC_B_CODE_W-1:0] = s_q.b_code;
        s_d.rdata[LDORC_EN_BIT] = s_q.b_enable;
        s_d.rdata[LDORC_PRESET_BIT] = s_q.b_preset_sel;
      end
      else if (!pwrite && hit_st)
      begin
        s_d.rdata[LDORC_ST_B_CODE_LSB +: LDORC_B_CODE_W] = ramp_code;
        s_d.rdata[LDORC_ST_A_CODE_LSB +: LDORC_A_CODE_W] = s_q.a_applied;
        s_d.rdata[LDORC_ST_A_EN_BIT] = s_q.a_on;
        s_d.rdata[LDORC_ST_B_EN_BIT] = s_q.b_on;
        s_d.rdata[LDORC_ST_RAMP_BIT] = ramp_busy;
        s_d.rdata[LDORC_ST_PD_BIT] = power_down;
      end
    end
    else
    begin
      // Error stands only beside ready
      s_d.slverr = 1'b0;
    end

    // Register writes, low byte lane only; status is read-only
    if (commit && pwrite && pstrb[0])
    begin
      if (hit_a)
      begin
        s_d.a_code = pwdata[LDORC_A_CODE_W-1:0];
        s_d.a_enable = pwdata[LDORC_EN_BIT];
        s_d.a_preset_sel = pwdata[LDORC_PRESET_BIT];
      end
      else if (hit_b)
      begin
        s_d.b_code = pwdata[LDORC_B_CODE_W-1:0];
        s_d.b_enable = pwdata[LDORC_EN_BIT];
        s_d.b_preset_sel = pwdata[LDORC_PRESET_BIT];
      end
    end

    // Regulator A output control
    if (power_down)
    begin
      if (s_q.a_preset_sel)
      begin
        s_d.a_applied = 5'(clamp_code({1'b0, s_q.a_code}, LDORC_A_CODE_MAX));
        s_d.a_on = 1'b1;
      end
      else
      begin
        s_d.a_on = 1'b0;
      end
    end
    else
    begin
      s_d.a_on = s_q.a_enable;
      if (!s_q.a_preset_sel)
      begin
        s_d.a_applied = 5'(clamp_code({1'b0, s_q.a_code}, LDORC_A_CODE_MAX));
      end
    end

    // Regulator B enable; voltage comes from the ramp engine
    if (power_down)
    begin
      // stays on while ramping to preset
      s_d.b_on = s_q.b_preset_sel;
    end
    else
    begin
      s_d.b_on = s_q.b_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.a_code <= LDORC_A_RESET[LDORC_A_CODE_W-1:0];
      s_q.a_enable <= LDORC_A_RESET[LDORC_EN_BIT];
      s_q.a_preset_sel <= LDORC_A_RESET[LDORC_PRESET_BIT];
      s_q.b_code <= LDORC_B_RESET[LDORC_B_CODE_W-1:0];
      s_q.b_enable <= LDORC_B_RESET[LDORC_EN_BIT];
      s_q.b_preset_sel <= LDORC_B_RESET[LDORC_PRESET_BIT];
      s_q.a_applied <= LDORC_A_RESET[LDORC_A_CODE_W-1:0];
      s_q.a_on <= 1'b0;
      s_q.b_on <= 1'b0;
      s_q.pd_prev <= 1'b0;
      s_q.ready <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.slverr <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.ready;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr;
  assign regulator_a_applied_code = s_q.a_applied;
  assign regulator_a_on = s_q.a_on;
  assign regulator_b_applied_code = ramp_code;
  assign regulator_b_on = s_q.b_on;
  assign regulator_b_ramping = ramp_busy;

endmodule

// ===== ldorc_regs_assertions.sv
// Checker for the regulator control bank, watching only the top module's ports.
// Assumes one clock domain, pclk, with presetn as its asynchronous active-low reset.
`timescale 1ns/1ps
module ldorc_regs_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down,
  input wire logic regulator_b_ramp_go,
  input wire logic [ldorc_pkg::LDORC_A_CODE_W-1:0] regulator_a_applied_code,
  input wire logic [ldorc_pkg::LDORC_B_CODE_W-1:0] regulator_b_applied_code,
  input wire logic regulator_b_ramping
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_a_clamp;
    regulator_a_applied_code <= 5'h18;
  endproperty
  a_a_clamp: assert property (p_a_clamp) else $error("regulator A code above top");

  property p_b_clamp;
    regulator_b_applied_code <= 6'h30;
  endproperty
  a_b_clamp: assert property (p_b_clamp) else $error("regulator B code above top");

  // Code moves only after a write or a power-down
  property p_a_cause;
    $changed(regulator_a_applied_code) |-> $past(psel && penable && pready && pwrite, 2) || $past(power_down)
      || $past(power_down, 2);
  endproperty
  a_a_cause: assert property (p_a_cause) else $error("regulator A code moved without cause");

  property p_b_cause;
    $changed(regulator_b_applied_code) |-> $past(regulator_b_ramping);
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("regulator B code moved outside a ramp");

  property p_ramp_start;
    $rose(regulator_b_ramping) |-> $past(regulator_b_ramp_go) || power_down;
  endproperty
  a_ramp_start: assert property (p_ramp_start) else $error("ramp began without go or power-down");

  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held over two cycles");

  property p_rdy_access;
    pready |-> psel && penable;
  endproperty
  a_rdy_access: assert property (p_rdy_access) else $error("ready outside an access");

  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
endmodule

bind ldorc_regs ldorc_regs_checker u_chk
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .pslverr(pslverr),
  .power_down(power_down),
  .regulator_b_ramp_go(regulator_b_ramp_go),
  .regulator_a_applied_code(regulator_a_applied_code),
  .regulator_b_applied_code(regulator_b_applied_code),
  .regulator_b_ramping(regulator_b_ramping)
);

// ===== tb_ldorc_regs.sv
// Testbench for the regulator control bank: APB access, codes, go ramp, power-down presets.
// Assumes the design answers APB with one wait state and ramps one step per three cycles.
`timescale 1ns/1ps
module tb_ldorc_regs;
  import ldorc_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, power_down = 0, regulator_b_ramp_go = 0;
  logic [31:0] prdata, rd;
  logic er, regulator_a_on, regulator_b_on, regulator_b_ramping;
  logic [4:0] regulator_a_applied_code;
  logic [5:0] regulator_b_applied_code;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc_cnt = 0;

  // Short ramp step keeps the run brief
  ldorc_regs #(.RAMP_STEP_CYC(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .power_down, .regulator_b_ramp_go, .regulator_a_applied_code,
    .regulator_a_on, .regulator_b_applied_code, .regulator_b_on, .regulator_b_ramping);

  always #4 pclk = ~pclk;

  task automatic conclude;
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && cyc_cnt < 20000);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic wait_ramp;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 300 && regulator_b_ramping !== 1'b0; i++) @(posedge pclk);
  endtask

  task automatic t_reset;
    apb(1'b0, LDORC_ADDR_A, 8'h00);
    chk(rd, 32'h0000_000C);
    apb(1'b0, LDORC_ADDR_B, 8'h00);
    chk(rd, 32'h0000_0018);
    apb(1'b0, LDORC_ADDR_STATUS, 8'h00);
    chk(rd, 32'h0000_0C18);
    chk(32'({regulator_a_applied_code, regulator_b_applied_code}), 32'({5'h0C, 6'h18}));
    chk(32'({regulator_a_on, regulator_b_on, regulator_b_ramping}), 32'h0000_0000);
  endtask

  task automatic t_imm;
    logic [4:0] c [3] = '{5'h00, 5'h18, 5'h1F};
    logic [4:0] e [3] = '{5'h00, 5'h18, 5'h18};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, LDORC_ADDR_A, {3'h2, c[i]});
      repeat (2) @(posedge pclk);
      chk(32'(regulator_a_applied_code), 32'(e[i]));
      chk(32'(regulator_a_on), 32'h0000_0001);
      apb(1'b0, LDORC_ADDR_A, 8'h00);
      chk(rd, 32'({3'h2, c[i]}));
    end
    pstrb <= 4'h0;
    apb(1'b1, LDORC_ADDR_A, 8'h00);
    pstrb <= 4'hF;
    apb(1'b0, LDORC_ADDR_A, 8'h00);
    chk(rd, 32'h0000_005F);
    apb(1'b1, 12'h000, 8'hFF);
    chk(32'(er), 32'h0000_0001);
    // Error must drop with ready
    chk(32'(pslverr), 32'h0000_0000);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
  endtask

  task automatic t_ramp;
    apb(1'b1, LDORC_ADDR_B, 8'h7F);
    repeat (4) @(posedge pclk);
    chk(32'({regulator_b_ramping, regulator_b_applied_code}), 32'h0000_0018);
    regulator_b_ramp_go <= 1'b1;
    @(posedge pclk);
    regulator_b_ramp_go <= 1'b0;
    @(posedge pclk);
    chk(32'(regulator_b_ramping), 32'h0000_0001);
    wait_ramp();
    chk(32'(regulator_b_applied_code), 32'h0000_0030);
    chk(32'(regulator_b_on), 32'h0000_0001);
  endtask

  task automatic t_pd;
    apb(1'b1, LDORC_ADDR_A, 8'h85);
    apb(1'b1, LDORC_ADDR_B, 8'hA0);
    repeat (2) @(posedge pclk);
    chk(32'({regulator_a_on, regulator_a_applied_code}), 32'h0000_0018);
    chk(32'(regulator_b_applied_code), 32'h0000_0030);
    power_down <= 1'b1;
    wait_ramp();
    chk(32'({regulator_a_on, regulator_a_applied_code}), 32'h0000_0025);
    chk(32'({regulator_b_on, regulator_b_applied_code}), 32'h0000_0060);
    apb(1'b0, LDORC_ADDR_STATUS, 8'h00);
    chk(rd, 32'h000B_0520);
    power_down <= 1'b0;
    apb(1'b1, LDORC_ADDR_A, 8'h45);
    power_down <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(regulator_a_on), 32'h0000_0000);
    power_down <= 1'b0;
  endtask

  // Mid-run reset must bring back every reset value
  task automatic t_rst;
    apb(1'b1, LDORC_ADDR_A, 8'hDF);
    apb(1'b1, LDORC_ADDR_B, 8'hC1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
  endtask

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_imm();
    t_ramp();
    t_pd();
    t_rst();
    conclude();
  end
endmodule
